/* File: hw/fppe_top.sv */
// flash program/erase sequencer with block protection, apb register access
// assumes the array macro supplies its stored protect byte and takes the
// registered control lines; the low-power request is synchronous to pclk
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fppe_defines.svh"

module fppe_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// array side
	input  wire logic [7:0]  protect_byte_in,
	input  wire logic        low_power_req,
	output logic      [15:0] arr_addr,
	output logic      [7:0]  arr_data,
	output logic             arr_prog_strobe,
	output logic             arr_program,
	output logic             arr_erase,
	output logic             arr_mass,
	output logic             arr_hv,
	output logic             arr_standby
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic               wr_access;
	logic               rd_access;
	logic               hit_ctrl;
	logic               hit_prot;
	logic               hit_arrw;
	logic               hit_stat;
	logic               mapped;
	logic [15:0]        aw_addr;
	logic [7:0]         aw_data;
	logic               aw_in_array;
	logic [15:0]        prot_start;
	logic               target_prot;
	logic               any_prot;
	logic               want_pgm;
	logic               want_ers;
	logic               want_hv;

	logic               pgm_ff;
	logic               ers_ff;
	logic               mass_ff;
	logic               hv_ff;
	logic               nxt_pgm;
	logic               nxt_ers;
	logic               nxt_mass;
	logic               nxt_hv;
	fppe_pkg::fppe_seq_t seq_ff;
	fppe_pkg::fppe_seq_t nxt_seq;
	logic [15:0]        target_ff;
	logic [15:0]        nxt_target;
	logic               refused_ff;
	logic               nxt_refused;
	logic               rowfail_ff;
	logic               nxt_rowfail;
	logic               strobe_ff;
	logic               nxt_strobe;
	logic [15:0]        pa_ff;
	logic [15:0]        nxt_pa;
	logic [7:0]         pd_ff;
	logic [7:0]         nxt_pd;
	logic [31:0]        rdata_ff;
	logic [31:0]        nxt_rdata;
	logic               hv_ok;
	logic               set_refused;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// zero-wait slave; every access completes in its first access cycle
	assign pready      = 1'b1;
	assign wr_access   = psel & penable & pwrite;
	assign rd_access   = psel & penable & ~pwrite;
	assign hit_ctrl    = (paddr == `FPPE_CTRL_OFS);
	assign hit_prot    = (paddr == `FPPE_PROT_OFS);
	assign hit_arrw    = (paddr == `FPPE_ARRW_OFS);
	assign hit_stat    = (paddr == `FPPE_STAT_OFS);
	assign mapped      = hit_ctrl | hit_prot | hit_arrw | hit_stat;
	assign pslverr     = psel & penable & ~mapped;
	assign aw_addr     = pwdata[`FPPE_AW_ADDR_HI:`FPPE_AW_ADDR_LO];
	assign aw_data     = pwdata[`FPPE_AW_DATA_HI:0];
	// writes below the array base are not array writes and are dropped
	assign aw_in_array = aw_addr >= `FPPE_ARRAY_BASE;
	assign want_pgm    = pwdata[`FPPE_PGM_BIT];
	assign want_ers    = pwdata[`FPPE_ERS_BIT];
	assign want_hv     = pwdata[`FPPE_HV_BIT];

	// ----------------------------------------------------------------
	// protection decode of the latched target
	// ----------------------------------------------------------------
	fppe_protect_map u_protect_map (
		.protect_byte   (protect_byte_in),
		.test_addr      (target_ff),
		.start_addr     (prot_start),
		.addr_protected (target_prot),
		.any_protected  (any_prot)
	);

	// high voltage only after select, protect read and target write;
	// mass erase also needs a fully unprotected array
	assign hv_ok = (seq_ff == fppe_pkg::SEQ_TARGET_SET)
		&& (nxt_pgm | nxt_ers)
		&& !target_prot
		&& !(nxt_ers && nxt_mass && any_prot);

	// a refused high voltage request is remembered for status
	assign set_refused = wr_access && hit_ctrl && want_hv && !hv_ff && !hv_ok;

	// ----------------------------------------------------------------
	// control register next state
	// ----------------------------------------------------------------
	// a select that collides with the other one is simply not taken
	always_comb
	begin
		nxt_pgm  = pgm_ff;
		nxt_ers  = ers_ff;
		nxt_mass = mass_ff;
		nxt_hv   = hv_ff;
		if (wr_access && hit_ctrl)
		begin
			nxt_pgm  = want_pgm & ~ers_ff & ~(want_ers & ~pgm_ff);
			nxt_ers  = want_ers & ~pgm_ff & ~(want_pgm & ~ers_ff);
			nxt_mass = pwdata[`FPPE_MASS_BIT];
			// clearing is always allowed, setting only when earned
			nxt_hv   = want_hv & (hv_ff | hv_ok);
		end
	end

	// ----------------------------------------------------------------
	// sequence tracking and target capture
	// ----------------------------------------------------------------
	// the protect byte read counts only after a select, so stale reads
	// from before the operation cannot unlock high voltage
	always_comb
	begin
		nxt_seq    = seq_ff;
		nxt_target = target_ff;
		if (!(nxt_pgm | nxt_ers))
		begin
			nxt_seq = fppe_pkg::SEQ_IDLE;
		end
		else
		begin
			unique case (seq_ff)
				fppe_pkg::SEQ_IDLE:
				begin
					nxt_seq = fppe_pkg::SEQ_SELECTED;
				end
				fppe_pkg::SEQ_SELECTED:
				begin
					if (rd_access && hit_prot)
						nxt_seq = fppe_pkg::SEQ_PROT_READ;
				end
				fppe_pkg::SEQ_PROT_READ:
				begin
					if (wr_access && hit_arrw && aw_in_array)
					begin
						nxt_seq    = fppe_pkg::SEQ_TARGET_SET;
						nxt_target = aw_addr;
					end
				end
				fppe_pkg::SEQ_TARGET_SET:
				begin
					if (nxt_hv)
						nxt_seq = fppe_pkg::SEQ_HV_ON;
				end
				fppe_pkg::SEQ_HV_ON:
				begin
					// dropping high voltage returns to SEQ_SELECTED; the select is kept
					if (!nxt_hv)
						nxt_seq = fppe_pkg::SEQ_SELECTED;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// row programming and error flags
	// ----------------------------------------------------------------
	// a byte outside the latched row is latched into pa_ff and pd_ff but not strobed; the cycle fails
	always_comb
	begin
		nxt_strobe  = 1'b0;
		nxt_pa      = pa_ff;
		nxt_pd      = pd_ff;
		nxt_rowfail = rowfail_ff;
		nxt_refused = refused_ff;
		if (seq_ff == fppe_pkg::SEQ_IDLE && (nxt_pgm | nxt_ers))
		begin
			nxt_rowfail = 1'b0;
			nxt_refused = 1'b0;
		end
		if (wr_access && hit_arrw && aw_in_array)
		begin
			nxt_pa = aw_addr;
			nxt_pd = aw_data;
			if (seq_ff == fppe_pkg::SEQ_HV_ON && pgm_ff)
			begin
				if (aw_addr[`FPPE_ADDR_TOP_BIT:`FPPE_ROW_LO_BIT] ==
					target_ff[`FPPE_ADDR_TOP_BIT:`FPPE_ROW_LO_BIT])
					nxt_strobe = 1'b1;
				else
					nxt_rowfail = 1'b1;
			end
		end
		// setting a flag wins over the clear at operation start
		if (set_refused)
			nxt_refused = 1'b1;
	end

	// ----------------------------------------------------------------
	// read data mux
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (psel && !penable && !pwrite)
		begin
			nxt_rdata = 32'h0000_0000;
			if (hit_ctrl)
			begin
				nxt_rdata[`FPPE_PGM_BIT]  = pgm_ff;
				nxt_rdata[`FPPE_ERS_BIT]  = ers_ff;
				nxt_rdata[`FPPE_MASS_BIT] = mass_ff;
				nxt_rdata[`FPPE_HV_BIT]   = hv_ff;
			end
			else if (hit_prot)
				nxt_rdata[7:0] = protect_byte_in;
			else if (hit_arrw)
			begin
				nxt_rdata[`FPPE_AW_ADDR_HI:`FPPE_AW_ADDR_LO] = pa_ff;
				nxt_rdata[`FPPE_AW_DATA_HI:0]                = pd_ff;
			end
			else if (hit_stat)
			begin
				nxt_rdata[`FPPE_ST_SEQ_HI:0]  = seq_ff;
				nxt_rdata[`FPPE_ST_MBLK_BIT]  = any_prot;
				nxt_rdata[`FPPE_ST_PHIT_BIT]  = target_prot;
				nxt_rdata[`FPPE_ST_ROWF_BIT]  = rowfail_ff;
				nxt_rdata[`FPPE_ST_REFU_BIT]  = refused_ff;
			end
		end
	end

	assign prdata = rdata_ff;

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pgm_ff     <= 1'b0;
			ers_ff     <= 1'b0;
			mass_ff    <= 1'b0;
			hv_ff      <= 1'b0;
			seq_ff     <= fppe_pkg::SEQ_IDLE;
			target_ff  <= 16'h0000;
			refused_ff <= 1'b0;
			rowfail_ff <= 1'b0;
			strobe_ff  <= 1'b0;
			pa_ff      <= 16'h0000;
			pd_ff      <= 8'h00;
			rdata_ff   <= 32'h0000_0000;
		end
		else
		begin
			pgm_ff     <= nxt_pgm;
			ers_ff     <= nxt_ers;
			mass_ff    <= nxt_mass;
			hv_ff      <= nxt_hv;
			seq_ff     <= nxt_seq;
			target_ff  <= nxt_target;
			refused_ff <= nxt_refused;
			rowfail_ff <= nxt_rowfail;
			strobe_ff  <= nxt_strobe;
			pa_ff      <= nxt_pa;
			pd_ff      <= nxt_pd;
			rdata_ff   <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// array control drive
	// ----------------------------------------------------------------
	// low power only masks the drive; register state is kept so the
	// operation is suspended rather than lost
	fppe_array_drive u_array_drive (
		.pclk            (pclk),
		.presetn         (presetn),
		.req_pgm         (pgm_ff),
		.req_ers         (ers_ff),
		.req_mass        (mass_ff),
		.req_hv          (hv_ff),
		.req_strobe      (strobe_ff),
		.req_addr        (pa_ff),
		.req_data        (pd_ff),
		.standby_req     (low_power_req),
		.arr_addr        (arr_addr),
		.arr_data        (arr_data),
		.arr_prog_strobe (arr_prog_strobe),
		.arr_program     (arr_program),
		.arr_erase       (arr_erase),
		.arr_mass        (arr_mass),
		.arr_hv          (arr_hv),
		.arr_standby     (arr_standby)
	);

endmodule : fppe_top

/* File: inc/fppe_defines.svh */
// register offsets, field positions and fixed values of the flash sequencer
// assumes inclusion by bare name from the design modules and the bench
`ifndef FPPE_DEFINES_SVH
`define FPPE_DEFINES_SVH

// ----------------------------------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------------------------------
`define FPPE_CTRL_OFS     8'h00
`define FPPE_PROT_OFS     8'h04
`define FPPE_ARRW_OFS     8'h08
`define FPPE_STAT_OFS     8'h0C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FPPE_PGM_BIT      0
`define FPPE_ERS_BIT      1
`define FPPE_MASS_BIT     2
`define FPPE_HV_BIT       3

// ----------------------------------------------------------------
// array write register fields
// ----------------------------------------------------------------
`define FPPE_AW_ADDR_HI   31
`define FPPE_AW_ADDR_LO   16
`define FPPE_AW_DATA_HI   7

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define FPPE_ST_SEQ_HI    2
`define FPPE_ST_MBLK_BIT  3
`define FPPE_ST_PHIT_BIT  4
`define FPPE_ST_ROWF_BIT  5
`define FPPE_ST_REFU_BIT  6

// ----------------------------------------------------------------
// array geometry and protect byte values
// ----------------------------------------------------------------
`define FPPE_ARRAY_BASE   16'h8000
`define FPPE_ADDR_TOP_BIT 15
`define FPPE_PAGE_ZERO    7'h00
`define FPPE_UNPROT_BYTE  8'hFF
`define FPPE_ROW_LO_BIT   6

`endif

/* File: inc/fppe_pkg.sv */
// types shared by the flash sequencer modules
// assumes the defines header sits on the include path
package fppe_pkg;

	// ----------------------------------------------------------------
	// operation sequence of the control register
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_SELECTED,
		SEQ_PROT_READ,
		SEQ_TARGET_SET,
		SEQ_HV_ON
	} fppe_seq_t;

endpackage : fppe_pkg

/* File: hw/fppe_protect_map.sv */
// protect start address decode and protected-range test
// assumes the array occupies the upper half of a 16-bit space
`timescale 1ns/1ps
`include "fppe_defines.svh"

module fppe_protect_map (
	// protect byte as stored in the array
	input  wire logic [7:0]  protect_byte,
	// address under test
	input  wire logic [15:0] test_addr,
	// decode results
	output logic      [15:0] start_addr,
	output logic             addr_protected,
	output logic             any_protected
);

	// ----------------------------------------------------------------
	// start address and range
	// ----------------------------------------------------------------
	// the all-ones minus one value lands on the top 256 bytes by itself
	always_comb
	begin
		start_addr     = {1'b1, protect_byte, `FPPE_PAGE_ZERO};
		any_protected  = (protect_byte != `FPPE_UNPROT_BYTE);
		addr_protected = any_protected && test_addr[`FPPE_ADDR_TOP_BIT]
			&& (test_addr >= start_addr);
	end

endmodule : fppe_protect_map

/* File: hw/fppe_array_drive.sv */
// registered control lines toward the flash array and its charge pump
// assumes the array macro samples these on pclk
`timescale 1ns/1ps
`include "fppe_defines.svh"

module fppe_array_drive (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// requested controls
	input  wire logic        req_pgm,
	input  wire logic        req_ers,
	input  wire logic        req_mass,
	input  wire logic        req_hv,
	input  wire logic        req_strobe,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_data,
	input  wire logic        standby_req,
	// array side
	output logic      [15:0] arr_addr,
	output logic      [7:0]  arr_data,
	output logic             arr_prog_strobe,
	output logic             arr_program,
	output logic             arr_erase,
	output logic             arr_mass,
	output logic             arr_hv,
	output logic             arr_standby
);

	logic [15:0] nxt_addr;
	logic [7:0]  nxt_data;
	logic        nxt_strobe;
	logic        nxt_program;
	logic        nxt_erase;
	logic        nxt_mass;
	logic        nxt_hv;
	logic [15:0] addr_ff;
	logic [7:0]  data_ff;
	logic        strobe_ff;
	logic        program_ff;
	logic        erase_ff;
	logic        mass_ff;
	logic        hv_ff;
	logic        standby_ff;

	// ----------------------------------------------------------------
	// standby gating
	// ----------------------------------------------------------------
	// in standby every control drops so the pump and sense amps draw least
	always_comb
	begin
		nxt_addr    = standby_req ? '0 : req_addr;
		nxt_data    = standby_req ? '0 : req_data;
		nxt_strobe  = req_strobe & ~standby_req;
		nxt_program = req_pgm & ~standby_req;
		// erase lifts cells to ones, a program strobe pulls them to zero
		nxt_erase   = req_ers & ~standby_req;
		nxt_mass    = req_mass & req_ers & ~standby_req;
		nxt_hv      = req_hv & ~standby_req;
	end

	// registered outputs; read mode is untouched since reads bypass this
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_ff    <= 16'h0000;
			data_ff    <= 8'h00;
			strobe_ff  <= 1'b0;
			program_ff <= 1'b0;
			erase_ff   <= 1'b0;
			mass_ff    <= 1'b0;
			hv_ff      <= 1'b0;
			standby_ff <= 1'b0;
		end
		else
		begin
			addr_ff    <= nxt_addr;
			data_ff    <= nxt_data;
			strobe_ff  <= nxt_strobe;
			program_ff <= nxt_program;
			erase_ff   <= nxt_erase;
			mass_ff    <= nxt_mass;
			hv_ff      <= nxt_hv;
			standby_ff <= standby_req;
		end
	end

	assign arr_addr        = addr_ff;
	assign arr_data        = data_ff;
	assign arr_prog_strobe = strobe_ff;
	assign arr_program     = program_ff;
	assign arr_erase       = erase_ff;
	assign arr_mass        = mass_ff;
	assign arr_hv          = hv_ff;
	assign arr_standby     = standby_ff;

endmodule : fppe_array_drive

/* File: bench/fppe_top_checker.sv */
// concurrent checks on the ports of the flash sequencer top
// assumes one pclk domain and presetn asynchronous, active low
`timescale 1ns/1ps
`include "fppe_defines.svh"

module fppe_checker (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	// array side
	input wire logic [7:0]  protect_byte_in,
	input wire logic        low_power_req,
	input wire logic [15:0] arr_addr,
	input wire logic [7:0]  arr_data,
	input wire logic        arr_prog_strobe,
	input wire logic        arr_program,
	input wire logic        arr_erase,
	input wire logic        arr_mass,
	input wire logic        arr_hv,
	input wire logic        arr_standby
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	logic arr_wr;
	// array write access, the only legal cause of a program strobe
	assign arr_wr = psel && penable && pwrite && (paddr == `FPPE_ARRW_OFS);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sel_excl_a: assert property (!(arr_program && arr_erase))
		else $error("program and erase lines both active");
	hv_needs_sel_a: assert property ($rose(arr_hv) |-> arr_program || arr_erase)
		else $error("high voltage rose without a select");
	mass_block_a: assert property ($rose(arr_hv) && arr_mass
		|-> protect_byte_in == `FPPE_UNPROT_BYTE)
		else $error("mass erase high voltage with protection set");
	standby_quiet_a: assert property (arr_standby |-> !(arr_program || arr_erase || arr_mass
		|| arr_hv || arr_prog_strobe) && arr_addr == 16'h0000 && arr_data == 8'h00)
		else $error("array control active in standby");
	standby_entry_a: assert property (low_power_req |-> ##[1:2] arr_standby)
		else $error("standby not entered");
	standby_exit_a: assert property (!low_power_req |-> ##[1:2] !arr_standby)
		else $error("standby not left");
	strobe_gate_a: assert property (arr_prog_strobe |-> arr_program && arr_hv)
		else $error("strobe outside high voltage program");
	strobe_pulse_a: assert property (arr_prog_strobe |=> !arr_prog_strobe)
		else $error("strobe longer than one cycle");
	strobe_cause_a: assert property ($rose(arr_prog_strobe)
		|-> $past(arr_wr, 1) || $past(arr_wr, 2) || $past(arr_wr, 3))
		else $error("strobe without array write");
	prot_read_a: assert property (psel && penable && !pwrite && paddr == `FPPE_PROT_OFS
		|-> prdata[7:0] == protect_byte_in)
		else $error("protect byte read mismatch");
endmodule : fppe_checker

bind fppe_top fppe_checker fppe_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.protect_byte_in(protect_byte_in), .low_power_req(low_power_req),
	.arr_addr(arr_addr), .arr_data(arr_data), .arr_prog_strobe(arr_prog_strobe),
	.arr_program(arr_program), .arr_erase(arr_erase), .arr_mass(arr_mass),
	.arr_hv(arr_hv), .arr_standby(arr_standby)
);

/* File: bench/test_fppe_top.sv */
// self-checking bench for the flash sequencer, apb tasks and sequences
// assumes the defines header on the include path and the checker bound in
`timescale 1ns/1ps
`include "fppe_defines.svh"

`define CHK(nm, exp, got) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("Error %s expected %0h seen %0h", nm, exp, got); \
		end \
	end

module test_fppe_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, protect_byte_in, arr_data, strobe_data;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] arr_addr, strobe_addr;
	logic        low_power_req, arr_prog_strobe, arr_program, arr_erase, arr_mass;
	logic        arr_hv, arr_standby;
	int          mismatches, compares, strobes;

	fppe_top fppe_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .protect_byte_in(protect_byte_in),
		.low_power_req(low_power_req), .arr_addr(arr_addr), .arr_data(arr_data),
		.arr_prog_strobe(arr_prog_strobe), .arr_program(arr_program),
		.arr_erase(arr_erase), .arr_mass(arr_mass), .arr_hv(arr_hv),
		.arr_standby(arr_standby)
	);

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// strobe monitor, samples registered array lines at the edge
	always @(posedge pclk)
	begin
		if (arr_prog_strobe === 1'b1)
		begin
			strobes++;
			strobe_addr = arr_addr;
			strobe_data = arr_data;
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// one apb transfer; idle edge first so strobes never toggle in one step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1)
		begin
			mismatches++;
			$display("Error pready expected 1 seen %b", pready);
			end_of_test();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		`CHK(nm, exp, rd)
	endtask : rchk

	// select, read protect byte, latch target, then ask for high voltage
	task attempt(input logic [7:0] sel, input logic [7:0] prot, input logic [15:0] addr,
		input logic hv);
		protect_byte_in <= prot;
		apb(1'b1, `FPPE_CTRL_OFS, {24'h000000, sel});
		rchk("protect byte", `FPPE_PROT_OFS, {24'h000000, prot});
		apb(1'b1, `FPPE_ARRW_OFS, {addr, 16'h0000});
		apb(1'b1, `FPPE_CTRL_OFS, {24'h000000, sel | 8'h08});
		rchk("control hv", `FPPE_CTRL_OFS, {24'h000000, sel | {4'h0, hv, 3'h0}});
		`CHK("hv line", hv, arr_hv)
		`CHK("program line", sel[0], arr_program)
		`CHK("erase line", sel[1], arr_erase)
		`CHK("mass line", sel[2] & sel[1], arr_mass)
		apb(1'b0, `FPPE_STAT_OFS, 32'h00000000);
		`CHK("refused flag", !hv, rd[`FPPE_ST_REFU_BIT])
		// selects drop first, high voltage only after them
		apb(1'b1, `FPPE_CTRL_OFS, {28'h0000000, hv, 3'h0});
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000000);
	endtask : attempt

	// ----------------------------------------------------------------
	// watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		$display("Error watchdog expected finish seen hang");
		end_of_test();
	end

	initial
	begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		protect_byte_in = 8'hFF;
		low_power_req = 0;
		mismatches = 0;
		compares = 0;
		strobes = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk("control reset", `FPPE_CTRL_OFS, 32'h00000000);
		rchk("status reset", `FPPE_STAT_OFS, 32'h00000000);
		rchk("unmapped data", 8'h10, 32'h00000000);
		`CHK("unmapped error", 1'b1, err)
		$display("test reset done");
		attempt(8'h02, 8'hFF, 16'hFFFF, 1'b1);
		attempt(8'h02, 8'hFE, 16'hFF00, 1'b0);
		attempt(8'h02, 8'hFE, 16'hFEFF, 1'b1);
		attempt(8'h02, 8'hFD, 16'hFE80, 1'b0);
		attempt(8'h02, 8'hFD, 16'hFE7F, 1'b1);
		attempt(8'h01, 8'h10, 16'h8800, 1'b0);
		attempt(8'h01, 8'h10, 16'h87FF, 1'b1);
		attempt(8'h01, 8'h00, 16'h8000, 1'b0);
		attempt(8'h06, 8'hFE, 16'h8000, 1'b0);
		attempt(8'h06, 8'hFF, 16'h8000, 1'b1);
		$display("test protection done");
		// interlock, then high voltage without the protect read
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000001);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000003);
		rchk("program held", `FPPE_CTRL_OFS, 32'h00000001);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000000);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000003);
		rchk("both from idle", `FPPE_CTRL_OFS, 32'h00000000);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000002);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000003);
		rchk("erase held", `FPPE_CTRL_OFS, 32'h00000002);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h0000000A);
		rchk("hv skipped step", `FPPE_CTRL_OFS, 32'h00000002);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000000);
		$display("test interlock done");
		// row program with one good byte, one outside the row, then standby
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000001);
		apb(1'b0, `FPPE_PROT_OFS, 32'h00000000);
		apb(1'b1, `FPPE_ARRW_OFS, 32'h90000000);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000009);
		strobes = 0;
		apb(1'b1, `FPPE_ARRW_OFS, 32'h901000A5);
		repeat (4) @(posedge pclk);
		`CHK("strobe count", 1, strobes)
		`CHK("strobe addr", 16'h9010, strobe_addr)
		`CHK("strobe data", 8'hA5, strobe_data)
		apb(1'b1, `FPPE_ARRW_OFS, 32'h9040005A);
		apb(1'b0, `FPPE_STAT_OFS, 32'h00000000);
		repeat (4) @(posedge pclk);
		`CHK("row fail", 1'b1, rd[5])
		`CHK("strobe after row fail", 1, strobes)
		low_power_req <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("standby", 1'b1, arr_standby)
		`CHK("hv in standby", 1'b0, arr_hv)
		`CHK("program in standby", 1'b0, arr_program)
		rchk("control kept", `FPPE_CTRL_OFS, 32'h00000009);
		low_power_req <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK("hv resumed", 1'b1, arr_hv)
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000008);
		apb(1'b1, `FPPE_CTRL_OFS, 32'h00000000);
		$display("test program done");
		end_of_test();
	end
endmodule : test_fppe_top
